// ---- include/asle_pkg.sv ----
package asle_pkg;

   // Register indices; the byte address on APB is four times the index
   localparam logic [11:0] IDX_CLK_CTL    = 12'h009;
   localparam logic [11:0] IDX_LINK_CTL   = 12'h033;
   localparam logic [11:0] IDX_STATUS     = 12'h034;
   localparam logic [11:0] ADDR_CLK_CTL   = IDX_CLK_CTL << 2;
   localparam logic [11:0] ADDR_LINK_CTL  = IDX_LINK_CTL << 2;
   localparam logic [11:0] ADDR_STATUS    = IDX_STATUS << 2;

   // Field positions
   localparam int DCS_EN_BIT     = 0;
   localparam int SCR_EN_BIT     = 0;
   localparam int TAIL_OOR_BIT   = 3;
   localparam int ST_SYNC_BIT    = 0;
   localparam int ST_RD_BIT      = 1;
   localparam int ST_DCS_BIT     = 2;
   localparam int ST_FRAME_BIT   = 3;

   // Reset values
   localparam logic [7:0]  CLK_CTL_RST    = 8'h01;
   localparam logic [7:0]  LINK_CTL_RST   = 8'h00;
   localparam logic [14:0] SCR_SEED       = 15'h7fff;
   localparam logic        RD_RST         = 1'b0;

   // Control and data characters
   localparam logic [7:0]  K28_5          = 8'hbc;
   localparam logic [7:0]  K28_7          = 8'hfc;
   localparam logic [7:0]  D28_7          = 8'hfc;
   localparam logic [2:0]  TAIL_PAD       = 3'h0;
   localparam logic [3:0]  TAIL_NONE      = 4'h0;

   // Timing counts
   localparam logic [1:0]  SYNC_LOW_CYCLES = 2'h2;
   localparam int          DCS_MIN_MHZ     = 50;

   // Frame position, Gray coded along sync -> msb -> lsb
   typedef enum logic [1:0] {
      ST_SYNC = 2'b00,
      ST_MSB  = 2'b01,
      ST_LSB  = 2'b11
   } asle_state_t;

   // One converter word with its range flag
   typedef struct packed {
      logic        oor;
      logic [11:0] data;
   } asle_sample_t;

   // One octet headed for the line encoder
   typedef struct packed {
      logic       is_k;
      logic [7:0] octet;
   } asle_char_t;

endpackage

// ---- hw/asle_enc8b10b.sv ----
`timescale 1ns/1ns
// 8B/10B encoder; code bit 9 is line bit a, sent first.
// Control support is limited to K28.5 and K28.7, the only ones this lane sends.
module asle_enc8b10b
   import asle_pkg::*;
(
   input  wire asle_pkg::asle_char_t ch,
   input  wire logic                 rd_in,
   output logic [9:0]                code,
   output logic                      rd_out
);

   // 5b/6b codes for negative disparity, abcdei
   function automatic logic [5:0] six_neg(input logic [4:0] x);
      case (x)
         5'd0:    six_neg = 6'b100111;
         5'd1:    six_neg = 6'b011101;
         5'd2:    six_neg = 6'b101101;
         5'd3:    six_neg = 6'b110001;
         5'd4:    six_neg = 6'b110101;
         5'd5:    six_neg = 6'b101001;
         5'd6:    six_neg = 6'b011001;
         5'd7:    six_neg = 6'b111000;
         5'd8:    six_neg = 6'b111001;
         5'd9:    six_neg = 6'b100101;
         5'd10:   six_neg = 6'b010101;
         5'd11:   six_neg = 6'b110100;
         5'd12:   six_neg = 6'b001101;
         5'd13:   six_neg = 6'b101100;
         5'd14:   six_neg = 6'b011100;
         5'd15:   six_neg = 6'b010111;
         5'd16:   six_neg = 6'b011011;
         5'd17:   six_neg = 6'b100011;
         5'd18:   six_neg = 6'b010011;
         5'd19:   six_neg = 6'b110010;
         5'd20:   six_neg = 6'b001011;
         5'd21:   six_neg = 6'b101010;
         5'd22:   six_neg = 6'b011010;
         5'd23:   six_neg = 6'b111010;
         5'd24:   six_neg = 6'b110011;
         5'd25:   six_neg = 6'b100110;
         5'd26:   six_neg = 6'b010110;
         5'd27:   six_neg = 6'b110110;
         5'd28:   six_neg = 6'b001110;
         5'd29:   six_neg = 6'b101110;
         5'd30:   six_neg = 6'b011110;
         default: six_neg = 6'b101011;
      endcase
   endfunction

   // 3b/4b codes for negative disparity, fghj
   function automatic logic [3:0] four_neg(input logic [2:0] y);
      case (y)
         3'd0:    four_neg = 4'b1011;
         3'd1:    four_neg = 4'b1001;
         3'd2:    four_neg = 4'b0101;
         3'd3:    four_neg = 4'b1100;
         3'd4:    four_neg = 4'b1101;
         3'd5:    four_neg = 4'b1010;
         3'd6:    four_neg = 4'b0110;
         default: four_neg = 4'b1110;
      endcase
   endfunction

   wire [4:0] x = ch.octet[4:0];
   wire [2:0] y = ch.octet[7:5];

   // Six-bit sub-block; unbalanced codes and D.7 flip at positive disparity
   wire [5:0] six_base  = ch.is_k ? 6'b001111 : six_neg(x);
   wire       six_unbal = (six_base[0] + six_base[1] + six_base[2] + six_base[3] + six_base[4] + six_base[5]) != 3'd3;
   wire       six_flip  = rd_in & (six_unbal | ((x == 5'd7) & ~ch.is_k));
   wire [5:0] six       = six_flip ? ~six_base : six_base;
   wire       rd_mid    = rd_in ^ six_unbal;

   // Four-bit sub-block; alternate D.x.7 avoids a run of five
   wire       alt7      = (y == 3'd7) & ((~rd_mid & ((x == 5'd17) | (x == 5'd18) | (x == 5'd20)))
                                       | (rd_mid & ((x == 5'd11) | (x == 5'd13) | (x == 5'd14))));
   wire [3:0] four_base = alt7 ? 4'b0111 : four_neg(y);
   wire       four_unbal = (y == 3'd0) | (y == 3'd4) | (y == 3'd7);
   wire [3:0] four_d    = (rd_mid & (four_unbal | (y == 3'd3))) ? ~four_base : four_base;
   wire [3:0] four_k    = (y == 3'd7) ? (rd_mid ? 4'b1000 : 4'b0111) : (rd_mid ? 4'b1010 : 4'b0101);

   assign code   = {six, ch.is_k ? four_k : four_d};
   assign rd_out = rd_mid ^ four_unbal;

endmodule

// ---- hw/asle_lane_tx.sv ----
`timescale 1ns/1ns
// Operation
// - First octet of a frame carries sample bits 11 to 4, msb first.
// - Second octet carries sample bits 3 to 0 then four tail bits.
// - Top tail bit may carry the sample's out-of-range flag.
// - Link format register bit 3 picks the tail bit content.
// - Link format register bit 0 turns scrambling on; otherwise octets pass clear.
// - Scrambler is self-synchronizing with polynomial 1 + x^14 + x^15.
// - Every octet becomes one 10-bit 8B/10B symbol, two per sample.
// - K28.5 and K28.7 commas are sent; receiver finds frames from them.
// - Duty cycle stabilizer is on after reset, giving nominal 50% duty.
// - Clock conditioning register can switch the stabilizer off.
// - Correction loop need not work below a 50 MHz sample clock.
// - Sync low two cycles: send K28.5 until release, then msb octet.
module asle_lane_tx
   import asle_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire asle_pkg::asle_sample_t sample,
   output logic                        sample_taken,
   input  wire logic                   programmable_mode_pin_n,
   input  wire logic                   clock_rate_low,
   output logic [9:0]                  lane_symbol,
   output logic                        duty_cycle_stabilizer_en
);

   // Software registers
   logic [7:0]  clk_ctl;
   logic [7:0]  link_ctl;

   // Pin synchronisers
   logic        sync_meta;
   logic        sync_pin;
   logic        rate_meta;
   logic        rate_low;

   // Frame state
   asle_state_t state;
   asle_state_t next_state;
   logic [1:0]  low_cnt;
   logic [1:0]  next_low_cnt;

   // Data path state
   logic [7:0]  lsb_hold;
   logic [7:0]  prev_lsb;
   logic        prev_valid;
   logic [14:0] scr_state;
   logic        rd;

   // Self-synchronizing scrambler over one octet, msb first.
   // State bit 0 is the newest output; bits 13 and 14 are the x^14 and x^15 taps.
   function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] st);
      logic [14:0] s;
      logic [7:0]  o;
      s = st;
      o = 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
         o[i] = d[i] ^ s[13] ^ s[14];
         s    = {s[13:0], o[i]};
      end
      scramble = {s, o};
   endfunction

   // APB decode; the slave answers in the first access cycle
   wire         apb_setup   = psel & ~penable;
   wire         apb_access  = psel & penable & pready;
   wire         hit_clk     = paddr == ADDR_CLK_CTL;
   wire         hit_link    = paddr == ADDR_LINK_CTL;
   wire         hit_status  = paddr == ADDR_STATUS;
   wire         mapped      = hit_clk | hit_link | hit_status;
   wire         wr_clk      = apb_access & pwrite & hit_clk;
   wire         wr_link     = apb_access & pwrite & hit_link;

   // Control fields
   wire         scr_en      = link_ctl[SCR_EN_BIT];
   wire         tail_oor    = link_ctl[TAIL_OOR_BIT];
   wire         dcs_en      = clk_ctl[DCS_EN_BIT];

   // Below the minimum clock rate the loop is not relied on, so it reads back idle
   wire         dcs_active  = dcs_en & ~rate_low;

   // Status word shows the lane's own state
   wire [31:0]  status_word = {28'h000_0000, state == ST_LSB, dcs_active, rd, state == ST_SYNC};

   // Read data selection
   wire [31:0]  rd_mux = hit_clk    ? {24'h00_0000, clk_ctl}  :
                         hit_link   ? {24'h00_0000, link_ctl} :
                         hit_status ? status_word             :
                         32'h0000_0000;

   // APB answer registers; unmapped addresses get an error, writes to status are dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= apb_setup;
         pslverr <= apb_setup & ~mapped;
         prdata  <= apb_setup ? rd_mux : 32'h0000_0000;
      end
   end

   // Clock conditioning register; the stabilizer comes up enabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clk_ctl <= CLK_CTL_RST;
      else if (wr_clk)
         clk_ctl <= pwdata[7:0];
   end

   // Serial link format register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         link_ctl <= LINK_CTL_RST;
      else if (wr_link)
         link_ctl <= pwdata[7:0];
   end

   // Stabilizer enable drives the clock conditioning circuit directly
   assign duty_cycle_stabilizer_en = dcs_en;

   // Two-flop synchronisers for the sync pin and the slow clock flag.
   // Sync idles high so a reset does not fake a request.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_meta <= 1'b1;
         sync_pin  <= 1'b1;
         rate_meta <= 1'b0;
         rate_low  <= 1'b0;
      end
      else
      begin
         sync_meta <= programmable_mode_pin_n;
         sync_pin  <= sync_meta;
         rate_meta <= clock_rate_low;
         rate_low  <= rate_meta;
      end
   end

   // Count low cycles of the request; a single-cycle glitch is ignored
   wire         sync_request = ~sync_pin & (low_cnt == SYNC_LOW_CYCLES - 2'd1);
   assign next_low_cnt = sync_pin ? 2'd0 :
                         (low_cnt == SYNC_LOW_CYCLES - 2'd1) ? low_cnt : low_cnt + 2'd1;

   // Frame sequencer: commas while held in sync, else msb then lsb octet
   always_comb
   begin
      next_state = state;
      case (state)
         ST_SYNC:
            if (sync_pin)
               next_state = ST_MSB;
         ST_MSB:
            if (sync_request)
               next_state = ST_SYNC;
            else
               next_state = ST_LSB;
         ST_LSB:
            if (sync_request)
               next_state = ST_SYNC;
            else
               next_state = ST_MSB;
         default:
            next_state = ST_SYNC;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= ST_SYNC;
         low_cnt <= 2'd0;
      end
      else
      begin
         state   <= next_state;
         low_cnt <= next_low_cnt;
      end
   end

   // Octet formatting from the incoming sample
   wire [3:0]   tail     = tail_oor ? {sample.oor, TAIL_PAD} : TAIL_NONE;
   wire [7:0]   msb_raw  = sample.data[11:4];
   wire [7:0]   lsb_raw  = {sample.data[3:0], tail};
   wire         in_msb   = state == ST_MSB;
   wire         in_lsb   = state == ST_LSB;

   // Scrambling of the octet on air this cycle
   wire [7:0]   cur_raw  = in_msb ? msb_raw : lsb_hold;
   wire [22:0]  scr_res  = scramble(cur_raw, scr_state);
   wire [7:0]   cur_oct  = scr_en ? scr_res[7:0] : cur_raw;

   // A repeated clear lsb octet, or a scrambled D28.7, goes out as K28.7.
   // This keeps the receiver's frame check alive without extra overhead.
   wire         rep_clear = ~scr_en & prev_valid & (cur_raw == prev_lsb);
   wire         rep_scr   = scr_en & (cur_oct == D28_7);
   wire         use_k28_7 = in_lsb & (rep_clear | rep_scr);

   // Character presented to the encoder
   asle_char_t  enc_char;
   assign enc_char = (state == ST_SYNC) ? asle_char_t'{is_k: 1'b1, octet: K28_5} :
                     use_k28_7          ? asle_char_t'{is_k: 1'b1, octet: K28_7} :
                                          asle_char_t'{is_k: 1'b0, octet: cur_oct};

   // Line encoder
   logic [9:0]  enc_code;
   logic        enc_rd;

   asle_enc8b10b u_enc (
      .ch     (enc_char),
      .rd_in  (rd),
      .code   (enc_code),
      .rd_out (enc_rd)
   );

   // Symbol register and running disparity, carried through every symbol
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lane_symbol <= 10'h000;
         rd          <= RD_RST;
      end
      else
      begin
         lane_symbol <= enc_code;
         rd          <= enc_rd;
      end
   end

   // Sample hand-off: one sample per two symbols, taken with the msb octet
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sample_taken <= 1'b0;
         lsb_hold     <= 8'h00;
      end
      else
      begin
         sample_taken <= in_msb;
         if (in_msb)
            lsb_hold <= lsb_raw;
      end
   end

   // Previous lsb octet for repeat detection; cleared by resynchronisation
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_lsb   <= 8'h00;
         prev_valid <= 1'b0;
      end
      else if (state == ST_SYNC)
         prev_valid <= 1'b0;
      else if (in_lsb)
      begin
         prev_lsb   <= cur_raw;
         prev_valid <= 1'b1;
      end
   end

   // With scrambling on, the scrambler advances on every msb and lsb octet, K28.7 included; K28.5 leaves it untouched
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         scr_state <= SCR_SEED;
      else if (scr_en & (state != ST_SYNC))
         scr_state <= scr_res[22:8];
   end

endmodule

// ---- bench/asle_lane_tx_assertions.sv ----
`timescale 1ns/1ns
module asle_lane_tx_assertions
   import asle_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire asle_pkg::asle_sample_t sample,
   input wire logic                   sample_taken,
   input wire logic                   programmable_mode_pin_n,
   input wire logic                   clock_rate_low,
   input wire logic [9:0]             lane_symbol,
   input wire logic                   duty_cycle_stabilizer_en
);
   // Decodes; K28.5 commas are matched in either disparity
   wire mapped = paddr == ADDR_CLK_CTL || paddr == ADDR_LINK_CTL || paddr == ADDR_STATUS;
   wire k_now  = lane_symbol == 10'h0fa || lane_symbol == 10'h305;
   wire clk_wr = psel && penable && pready && pwrite && paddr == ADDR_CLK_CTL;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Setup phase, and a request long enough to clear the pin filter
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_sync_req;
      !programmable_mode_pin_n [*7];
   endsequence
   a_ready_next: assert property (s_setup |=> pready) else $error("ready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_err_decode: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong for address");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero when idle");
   a_dcs_write: assert property (clk_wr |=> ##1 duty_cycle_stabilizer_en == $past(pwdata[0], 2))
      else $error("stabilizer enable not following write");
   a_dcs_read: assert property (pready && !pwrite && paddr == ADDR_CLK_CTL
      |-> prdata[0] == duty_cycle_stabilizer_en) else $error("stabilizer readback differs");
   a_taken_space: assert property (sample_taken |=> !sample_taken) else $error("samples taken back to back");
   a_sync_comma: assert property (s_sync_req |-> k_now) else $error("no comma during sync request");
   a_sync_idle: assert property (s_sync_req |-> !sample_taken) else $error("sample taken during sync");
   a_symbol_weight: assert property ($past(presetn) |-> $countones(lane_symbol) inside {4, 5, 6})
      else $error("symbol weight out of range");
endmodule
bind asle_lane_tx asle_lane_tx_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sample(sample), .sample_taken(sample_taken), .clock_rate_low(clock_rate_low),
   .programmable_mode_pin_n(programmable_mode_pin_n), .lane_symbol(lane_symbol),
   .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en));

// ---- bench/asle_rx_model.sv ----
`timescale 1ns/1ns
module asle_rx_model
   import asle_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [9:0] lane_symbol,
   input  wire logic       resync,
   output logic            sync_n
);
   logic [2:0] kcnt;
   // Symbols taken on the shared clock stand in for the receiver's recovered clock
   wire        is_k = lane_symbol == 10'h0fa || lane_symbol == 10'h305;
   // Holds request while told, then releases after four commas in a row
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_n <= 1'b1;
         kcnt   <= 3'h0;
      end
      else if (resync)
      begin
         sync_n <= 1'b0;
         kcnt   <= 3'h0;
      end
      else if (!sync_n)
      begin
         kcnt <= is_k ? kcnt + 3'h1 : 3'h0;
         if (is_k && kcnt == 3'h3)
            sync_n <= 1'b1;
      end
   end
endmodule

// ---- bench/test_adc_serial_lane_encoder.sv ----
`timescale 1ns/1ns
module test_adc_serial_lane_encoder;
   import asle_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_taken, sync_n, clock_rate_low, duty_cycle_stabilizer, resync;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, seed;
   logic [9:0] lane;
   logic [7:0] cfg, prev, oct;
   logic [14:0] sc;
   logic e, live, kk;
   asle_sample_t sample, hold;
   int bad_count, n_tests, cyc, mode, quiet;
   bit rd, r0, first, scr_on, tail_on;
   logic [5:0] t6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15,
      6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   logic [3:0] t4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   asle_lane_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
      .sample_taken(sample_taken), .programmable_mode_pin_n(sync_n), .clock_rate_low(clock_rate_low),
      .lane_symbol(lane), .duty_cycle_stabilizer_en(duty_cycle_stabilizer));
   asle_rx_model rx (.pclk(pclk), .presetn(presetn), .lane_symbol(lane), .resync(resync), .sync_n(sync_n));
   always #10 pclk = ~pclk;
   task end_sim;
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   // APB master; holds the request until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // Reference 8B/10B encoder; running disparity lives in rd
   function automatic logic [9:0] enc(input logic [7:0] o, input bit k);
      logic [5:0] a;
      logic [3:0] b;
      int x, y;
      x = o[4:0];
      y = o[7:5];
      if (k)
      begin
         enc = rd ? (o == K28_5 ? 10'h305 : 10'h307) : (o == K28_5 ? 10'h0fa : 10'h0f8);
         // K28.5 is unbalanced and flips disparity; K28.7 is balanced and keeps it
         if (o == K28_5) rd = !rd;
         return enc;
      end
      a = t6[x];
      if (rd && ($countones(a) != 3 || x == 7)) a = ~a;
      if ($countones(a) != 3) rd = !rd;
      b = t4[y];
      if (y == 7 && (rd ? (x == 11 || x == 13 || x == 14) : (x == 17 || x == 18 || x == 20))) b = 4'h7;
      if (rd && ($countones(b) != 2 || y == 3)) b = ~b;
      if ($countones(b) != 2) rd = !rd;
      return {a, b};
   endfunction
   // Reference scrambler shares the DUT's tap history, so it reproduces the scrambled octet
   function automatic logic [7:0] scr(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
      begin
         scr[i] = d[i] ^ sc[13] ^ sc[14];
         sc = {sc[13:0], scr[i]};
      end
   endfunction
   // Reference lane model, checked once per symbol at the settled half
   always @(negedge pclk)
   begin
      if (!presetn)
      begin
         rd = RD_RST; sc = SCR_SEED; mode = 0; first = 1; scr_on = 0; tail_on = 0; quiet = 0;
      end
      else if (live)
      begin
         quiet = sync_n ? quiet + 1 : 0;
         r0 = rd;
         if (lane === enc(K28_5, 1) && (mode == 0 || quiet < 8))
         begin
            mode = 0;
            first = 1;
         end
         else if (mode != 2)
         begin
            rd = r0;
            hold = sample;
            chk("msb", lane, enc(scr_on ? scr(hold.data[11:4]) : hold.data[11:4], 0));
            chk("taken", sample_taken, 1);
            mode = 2;
         end
         else
         begin
            rd = r0;
            cfg = {hold.data[3:0], tail_on ? {hold.oor, TAIL_PAD} : TAIL_NONE};
            oct = scr_on ? scr(cfg) : cfg;
            kk = scr_on ? oct == D28_7 : (!first && cfg == prev);
            chk("lsb", lane, enc(kk ? K28_7 : oct, kk));
            prev = cfg; first = 0; mode = 1;
         end
      end
   end
   // New converter word after each take; low nibble repeats often
   always @(posedge pclk)
   begin
      live <= presetn;
      cyc++;
      if (sample_taken === 1'b1)
      begin
         seed = xs(seed);
         sample <= {seed[12], seed[11:4], seed[20] ? 4'h5 : seed[3:0]};
      end
      // Ceiling well above the few thousand cycles the scenarios take
      if (cyc == 6000)
      begin
         bad_count++;
         end_sim;
      end
   end
   initial
   begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sample = 0;
      clock_rate_low = 0; resync = 0; seed = 32'h9d9c_0c33; bad_count = 0; n_tests = 0; cyc = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(0, ADDR_CLK_CTL, 0); chk("clk_rst", r, 32'h0000_0001);
      chk("dcs_rst", duty_cycle_stabilizer, 1);
      apb(0, ADDR_LINK_CTL, 0); chk("link_rst", r, 32'h0000_0000);
      apb(1, 12'h100, 32'h0000_00ff); chk("unmapped", {r[30:0], e}, 1);
      repeat (200) @(posedge pclk);
      for (int i = 0; i < 4; i++)
      begin
         // Format changes only while commas go out, so no frame mixes two modes
         resync <= 1;
         repeat (10) @(posedge pclk);
         apb(1, ADDR_LINK_CTL, {28'h0, i[1], 2'b00, i[0]}); apb(0, ADDR_LINK_CTL, 0);
         chk("link", r, {28'h0, i[1], 2'b00, i[0]});
         apb(0, ADDR_STATUS, 0); chk("st_sync", {r[ST_FRAME_BIT], r[ST_SYNC_BIT]}, 1);
         scr_on = i[0]; tail_on = i[1];
         resync <= 0;
         repeat (20) @(posedge pclk);
         chk("data_mode", mode != 0, 1);
         repeat (i[0] ? 700 : 200) @(posedge pclk);
      end
      apb(1, ADDR_CLK_CTL, 0); apb(0, ADDR_CLK_CTL, 0); chk("clk_off", {r[7:0], duty_cycle_stabilizer}, 0);
      apb(1, ADDR_CLK_CTL, 1); clock_rate_low <= 1; repeat (4) @(posedge pclk);
      apb(0, ADDR_STATUS, 0); chk("st_low", r[ST_DCS_BIT], 0);
      clock_rate_low <= 0; repeat (4) @(posedge pclk);
      apb(1, ADDR_STATUS, 32'h0000_00ff); chk("st_wr", e, 0);
      apb(0, ADDR_STATUS, 0); chk("st_on", r[ST_DCS_BIT], 1);
      apb(1, ADDR_CLK_CTL, 0);
      presetn <= 0; repeat (3) @(posedge pclk);
      presetn <= 1; repeat (100) @(posedge pclk);
      chk("dcs_rerst", duty_cycle_stabilizer, 1);
      end_sim;
   end
endmodule
